// ==== design/ecram_pkg.sv ====
// Shared constants, types and decoding for the configurable embedded RAM.
// Assumes the user compiles it before every other design file.
package ecram_pkg;

  // ----------------------------------------------------------------------
  // Block kinds, port modes and the per-port request carrier
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_SMALL  = 3'h1,
    KIND_MEDIUM = 3'h2,
    KIND_LARGE  = 3'h4
  } ecram_kind_t;

  typedef enum logic [3:0] {
    MODE_SP  = 4'h1,
    MODE_SDP = 4'h2,
    MODE_TDP = 4'h4,
    MODE_DSP = 4'h8
  } ecram_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
  } ecram_ctl_t;

  // ----------------------------------------------------------------------
  // Capacities and width limits
  // ----------------------------------------------------------------------
  localparam int SMALL_DATA_BITS = 512;
  localparam int SMALL_PAR_BITS = 576;
  localparam int MEDIUM_DATA_BITS = 4096;
  localparam int MEDIUM_PAR_BITS = 4608;
  localparam int LARGE_DATA_BITS = 524288;
  localparam int LARGE_PAR_BITS = 589824;
  localparam int SMALL_MAX_W = 18;
  localparam int MEDIUM_MAX_W = 36;
  localparam int LARGE_MAX_W = 144;
  localparam int SMALL_MIN_W = 1;
  localparam int MEDIUM_MIN_W = 1;
  localparam int LARGE_MIN_W = 8;
  localparam int PARITY_GROUP = 9;

  // ----------------------------------------------------------------------
  // Reset and read-during-write values
  // ----------------------------------------------------------------------
  localparam int RST_SYNC_STAGES = 2;
  localparam logic Q_RESET_BIT = 1'b0;
  localparam logic RDW_FILL_BIT = 1'b1;

  // ----------------------------------------------------------------------
  // Decoding shared by the top and its checks
  // ----------------------------------------------------------------------
  function automatic bit isParity(input int w);
    return (w % PARITY_GROUP) == 0;
  endfunction

  function automatic bit isPow2(input int v);
    return (v > 0) && ((v & (v - 1)) == 0);
  endfunction

  function automatic int maxWidth(input ecram_kind_t k);
    return (k == KIND_SMALL) ? SMALL_MAX_W :
           (k == KIND_MEDIUM) ? MEDIUM_MAX_W : LARGE_MAX_W;
  endfunction

  function automatic int minWidth(input ecram_kind_t k);
    return (k == KIND_SMALL) ? SMALL_MIN_W :
           (k == KIND_MEDIUM) ? MEDIUM_MIN_W : LARGE_MIN_W;
  endfunction

  function automatic int blockBits(input ecram_kind_t k, input int w);
    if (k == KIND_SMALL) begin
      return isParity(w) ? SMALL_PAR_BITS : SMALL_DATA_BITS;
    end
    if (k == KIND_MEDIUM) begin
      return isParity(w) ? MEDIUM_PAR_BITS : MEDIUM_DATA_BITS;
    end
    return isParity(w) ? LARGE_PAR_BITS : LARGE_DATA_BITS;
  endfunction

  function automatic bit widthOk(input ecram_kind_t k, input int w);
    bit shapeOk;
    shapeOk = isParity(w) ? isPow2(w / PARITY_GROUP) : isPow2(w);
    return shapeOk && (w <= maxWidth(k)) &&
           (isParity(w) || (w >= minWidth(k)));
  endfunction

  function automatic bit hasInClear(input ecram_kind_t k);
    return k != KIND_LARGE;
  endfunction

endpackage

// ==== design/ecram_rst_sync.sv ====
// Reset release synchroniser for the embedded RAM.
// Assumes an active-low reset that may assert at any time.
`timescale 1ns/1ps

module ecram_rst_sync #(
  parameter int STAGES = ecram_pkg::RST_SYNC_STAGES
) (
  // Clock and raw reset
  input wire logic mclk,
  input wire logic nrst,
  // Synchronised reset
  output logic rstN
);

  logic [STAGES-1:0] syncChain_r;

  generate
    if (STAGES < 2) begin : gBadStages
      $error("ecram_rst_sync needs at least two stages");
    end
  endgenerate

  // Assertion is immediate, release walks through the chain.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncChain_r <= '0;
    end else begin
      syncChain_r <= {syncChain_r[STAGES-2:0], 1'b1};
    end
  end

  assign rstN = syncChain_r[STAGES-1];

endmodule

// ==== design/ecram_mem.sv ====
// Storage array with two lane-addressed ports and registered read data.
// Assumes requests arrive already registered on the same clock.
`timescale 1ns/1ps

module ecram_mem #(
  parameter int WORD_W = 36,
  parameter int NWORDS = 128,
  parameter int WIDTH_A = 36,
  parameter int WIDTH_B = 36,
  parameter int AW_A = 7,
  parameter int AW_B = 7,
  parameter bit WRITE_THRU = 1'b0,
  parameter bit RDW_OLD = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstN,
  // Port A
  input wire ecram_pkg::ecram_ctl_t ctlA,
  input wire logic [AW_A-1:0] addrA,
  input wire logic [WIDTH_A-1:0] wdA,
  output logic [WIDTH_A-1:0] rdA,
  // Port B
  input wire ecram_pkg::ecram_ctl_t ctlB,
  input wire logic [AW_B-1:0] addrB,
  input wire logic [WIDTH_B-1:0] wdB,
  output logic [WIDTH_B-1:0] rdB
);

  localparam int RATIO_A = WORD_W / WIDTH_A;
  localparam int RATIO_B = WORD_W / WIDTH_B;
  localparam int WAW = $clog2(NWORDS);

  logic [WORD_W-1:0] mem [NWORDS];
  logic [WIDTH_A-1:0] rdA_r;
  logic [WIDTH_B-1:0] rdB_r;
  logic [WORD_W-1:0] mergeA;
  logic [WORD_W-1:0] mergeB;

  // ----------------------------------------------------------------------
  // Word and lane decode
  // ----------------------------------------------------------------------
  wire [WAW-1:0] wordA = WAW'(addrA / RATIO_A);
  wire [WAW-1:0] wordB = WAW'(addrB / RATIO_B);
  wire integer offA = int'(addrA % RATIO_A) * WIDTH_A;
  wire integer offB = int'(addrB % RATIO_B) * WIDTH_B;
  wire [WIDTH_A-1:0] fillA = {WIDTH_A{ecram_pkg::RDW_FILL_BIT}};
  wire [WIDTH_B-1:0] fillB = {WIDTH_B{ecram_pkg::RDW_FILL_BIT}};
  wire sameWord = wordA == wordB;
  wire [WIDTH_A-1:0] oldA = mem[wordA][offA +: WIDTH_A];
  wire [WIDTH_B-1:0] oldB = mem[wordB][offB +: WIDTH_B];
  wire hazA = ctlA.rd && ctlB.wr && sameWord;
  wire hazB = ctlB.rd && ctlA.wr && sameWord;

  // ----------------------------------------------------------------------
  // Writes: each port replaces only its own lane of the wide word
  // ----------------------------------------------------------------------
  always_comb begin
    mergeA = mem[wordA];
    mergeA[offA +: WIDTH_A] = wdA;
  end

  // A second write to the same word builds on the first one.
  always_comb begin
    mergeB = (ctlA.wr && sameWord) ? mergeA : mem[wordB];
    mergeB[offB +: WIDTH_B] = wdB;
  end

  always_ff @(posedge mclk) begin
    if (ctlA.wr) begin
      mem[wordA] <= mergeA;
    end
    if (ctlB.wr) begin
      mem[wordB] <= mergeB;
    end
  end

  // ----------------------------------------------------------------------
  // Reads: registered, holding when idle
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdA_r <= {WIDTH_A{ecram_pkg::Q_RESET_BIT}};
    end else if (WRITE_THRU && ctlA.wr) begin
      rdA_r <= wdA;
    end else if (ctlA.rd) begin
      rdA_r <= (hazA && !RDW_OLD) ? fillA : oldA;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdB_r <= {WIDTH_B{ecram_pkg::Q_RESET_BIT}};
    end else if (WRITE_THRU && ctlB.wr) begin
      rdB_r <= wdB;
    end else if (ctlB.rd) begin
      rdB_r <= (hazB && !RDW_OLD) ? fillB : oldB;
    end
  end

  assign rdA = rdA_r;
  assign rdB = rdB_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [WAW-1:0] lastWordA_r;
  int lastOffA_r;
  logic [WIDTH_A-1:0] lastDataA_r;

  always_ff @(posedge mclk) begin
    lastWordA_r <= wordA;
    lastOffA_r <= offA;
    lastDataA_r <= wdA;
  end

  sequence sSoleWriteA;
    ctlA.wr && !(ctlB.wr && sameWord);
  endsequence

  chk_a_lands_lane: assert property (
    @(posedge mclk) disable iff (!rstN)
    sSoleWriteA |=> mem[lastWordA_r][lastOffA_r +: WIDTH_A] == lastDataA_r)
    else $error("port A write did not land in its lane");

  chk_rdw_fill: assert property (
    @(posedge mclk) disable iff (!rstN)
    !RDW_OLD && hazA && !(WRITE_THRU && ctlA.wr)
      |=> rdA_r == {WIDTH_A{ecram_pkg::RDW_FILL_BIT}})
    else $error("colliding read on port A did not return fill");

  chk_rdw_old_b: assert property (
    @(posedge mclk) disable iff (!rstN)
    RDW_OLD && hazB && !(WRITE_THRU && ctlB.wr) |=> rdB_r == $past(oldB))
    else $error("colliding read on port B did not return old data");

endmodule

// ==== design/ecram_top.sv ====
// Configurable embedded RAM block: kind, port mode, widths and output
// registers are chosen by parameters; both ports share one clock.
// Assumes user logic on mclk drives all port inputs and both clears.
`timescale 1ns/1ps

// Function
// - True dual-port medium and large blocks accept any read/write pair.
// - Simple dual-port reads and writes together; collisions give old or fill.
// - Single-port write shows on q after write, or one edge later registered.
// - Medium block splits into two single-port halves.
// - The two ports may have different widths over shared storage.
// - All port inputs are registered; the write strobe comes from the clock.
// - Output registers are optional and add one pipeline stage.
// - Input clear acts at once; a bypassed output shows it from the next edge, a registered one an edge later.
// - Output clear zeroes registered read data immediately; a bypassed port ignores it.
// - Small and medium clear input and output; large only output.
module ecram_top #(
  parameter ecram_pkg::ecram_kind_t KIND = ecram_pkg::KIND_MEDIUM,
  parameter ecram_pkg::ecram_mode_t MODE = ecram_pkg::MODE_TDP,
  parameter int WIDTH_A = 36,
  parameter int WIDTH_B = 36,
  parameter bit OUT_REG_A = 1'b1,
  parameter bit OUT_REG_B = 1'b1,
  parameter bit RDW_OLD = 1'b1,
  localparam int BITS = ecram_pkg::blockBits(KIND, WIDTH_A),
  localparam int AW_A = $clog2(BITS / WIDTH_A),
  localparam int AW_B = $clog2(BITS / WIDTH_B)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Asynchronous register clears
  input wire logic inClr,
  input wire logic outClr,
  // Port A
  input wire logic [AW_A-1:0] addrA,
  input wire logic [WIDTH_A-1:0] wdataA,
  input wire logic weA,
  input wire logic reA,
  output logic [WIDTH_A-1:0] qA,
  output logic qKnownA,
  // Port B
  input wire logic [AW_B-1:0] addrB,
  input wire logic [WIDTH_B-1:0] wdataB,
  input wire logic weB,
  input wire logic reB,
  output logic [WIDTH_B-1:0] qB,
  output logic qKnownB
);

  localparam int WORD_W = (WIDTH_A > WIDTH_B) ? WIDTH_A : WIDTH_B;
  localparam bit HAS_IN_CLR = ecram_pkg::hasInClear(KIND);
  localparam bit IS_LARGE = KIND == ecram_pkg::KIND_LARGE;
  localparam bit IS_SP = MODE == ecram_pkg::MODE_SP;
  localparam bit IS_SDP = MODE == ecram_pkg::MODE_SDP;
  localparam bit IS_TDP = MODE == ecram_pkg::MODE_TDP;
  localparam bit IS_DSP = MODE == ecram_pkg::MODE_DSP;
  localparam bit WRITE_THRU = IS_SP || IS_DSP;
  localparam bit RDW_OLD_EFF = RDW_OLD && !IS_LARGE;
  localparam bit KNOWN_AT_RESET = !IS_LARGE;

  // ----------------------------------------------------------------------
  // Configuration checks
  // ----------------------------------------------------------------------
  generate
    if (!ecram_pkg::widthOk(KIND, WIDTH_A) ||
        !ecram_pkg::widthOk(KIND, WIDTH_B)) begin : gBadWidth
      $error("port width not offered by this block kind");
    end
    if (ecram_pkg::blockBits(KIND, WIDTH_B) != BITS) begin : gBadMix
      $error("ports mix parity and plain widths");
    end
    if (KIND == ecram_pkg::KIND_SMALL && (IS_TDP || IS_DSP)) begin : gBadSm
      $error("small block has no true dual-port mode");
    end
    if (IS_DSP && KIND != ecram_pkg::KIND_MEDIUM) begin : gBadDsp
      $error("split single-port mode needs a medium block");
    end
    if (IS_DSP && AW_A < 2) begin : gBadHalf
      $error("split halves need an address bit to spare");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Reset release and clear domains
  // ----------------------------------------------------------------------
  logic rstN;

  ecram_rst_sync #(
    .STAGES(ecram_pkg::RST_SYNC_STAGES)
  ) uRstSync (
    .mclk(mclk),
    .nrst(nrst),
    .rstN(rstN)
  );

  wire inRstN = rstN && !(HAS_IN_CLR && inClr);
  wire outRstN = rstN && !outClr;

  // ----------------------------------------------------------------------
  // Request gating per mode
  // ----------------------------------------------------------------------
  ecram_pkg::ecram_ctl_t ctlA_nxt;
  ecram_pkg::ecram_ctl_t ctlB_nxt;
  ecram_pkg::ecram_ctl_t ctlA_r;
  ecram_pkg::ecram_ctl_t ctlB_r;

  // A write on a single-port memory takes the cycle; its read is dropped.
  assign ctlA_nxt.wr = weA;
  assign ctlA_nxt.rd = reA && !IS_SDP && !(WRITE_THRU && weA);
  assign ctlB_nxt.wr = weB && (IS_TDP || IS_DSP);
  assign ctlB_nxt.rd = reB && !IS_SP && !(IS_DSP && weB);

  // ----------------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------------
  logic [AW_A-1:0] addrA_r;
  logic [AW_B-1:0] addrB_r;
  logic [WIDTH_A-1:0] wdA_r;
  logic [WIDTH_B-1:0] wdB_r;

  // The registered write request is the block's own write strobe.
  always_ff @(posedge mclk or negedge inRstN) begin
    if (!inRstN) begin
      ctlA_r <= '0;
      ctlB_r <= '0;
      addrA_r <= '0;
      addrB_r <= '0;
      wdA_r <= '0;
      wdB_r <= '0;
    end else begin
      ctlA_r <= ctlA_nxt;
      ctlB_r <= ctlB_nxt;
      addrA_r <= addrA;
      addrB_r <= addrB;
      wdA_r <= wdataA;
      wdB_r <= wdataB;
    end
  end

  // Split mode pins each port to its own half of the array.
  logic [AW_A-1:0] memAddrA;
  logic [AW_B-1:0] memAddrB;

  assign memAddrA = IS_DSP ? {1'b0, addrA_r[AW_A-2:0]} : addrA_r;
  assign memAddrB = IS_DSP ? {1'b1, addrB_r[AW_B-2:0]} : addrB_r;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [WIDTH_A-1:0] memRdA;
  logic [WIDTH_B-1:0] memRdB;

  ecram_mem #(
    .WORD_W(WORD_W),
    .NWORDS(BITS / WORD_W),
    .WIDTH_A(WIDTH_A),
    .WIDTH_B(WIDTH_B),
    .AW_A(AW_A),
    .AW_B(AW_B),
    .WRITE_THRU(WRITE_THRU),
    .RDW_OLD(RDW_OLD_EFF)
  ) uMem (
    .mclk(mclk),
    .rstN(rstN),
    .ctlA(ctlA_r),
    .addrA(memAddrA),
    .wdA(wdA_r),
    .rdA(memRdA),
    .ctlB(ctlB_r),
    .addrB(memAddrB),
    .wdB(wdB_r),
    .rdB(memRdB)
  );

  // ----------------------------------------------------------------------
  // Optional output registers
  // ----------------------------------------------------------------------
  generate
    if (OUT_REG_A) begin : gOutRegA
      logic [WIDTH_A-1:0] qA_r;
      always_ff @(posedge mclk or negedge outRstN) begin
        if (!outRstN) begin
          qA_r <= {WIDTH_A{ecram_pkg::Q_RESET_BIT}};
        end else begin
          qA_r <= memRdA;
        end
      end
      assign qA = qA_r;
    end else begin : gBypassA
      assign qA = memRdA;
    end
    if (OUT_REG_B) begin : gOutRegB
      logic [WIDTH_B-1:0] qB_r;
      always_ff @(posedge mclk or negedge outRstN) begin
        if (!outRstN) begin
          qB_r <= {WIDTH_B{ecram_pkg::Q_RESET_BIT}};
        end else begin
          qB_r <= memRdB;
        end
      end
      assign qB = qB_r;
    end else begin : gBypassB
      assign qB = memRdB;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output validity
  // ----------------------------------------------------------------------
  logic qKnownA_r;
  logic qKnownB_r;
  wire defineA = ctlA_r.rd || (WRITE_THRU && ctlA_r.wr) ||
                 (OUT_REG_A && outClr);
  wire defineB = ctlB_r.rd || (WRITE_THRU && ctlB_r.wr) ||
                 (OUT_REG_B && outClr);

  // A large block's data means nothing until a read, a write-through write or an output clear on a registered port.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      qKnownA_r <= KNOWN_AT_RESET;
      qKnownB_r <= KNOWN_AT_RESET;
    end else begin
      qKnownA_r <= qKnownA_r || defineA;
      qKnownB_r <= qKnownB_r || defineB;
    end
  end

  assign qKnownA = qKnownA_r;
  assign qKnownB = qKnownB_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence sCleanWriteA;
    IS_SP && weA && !inClr ##1 !inClr;
  endsequence

  generate
    if (!OUT_REG_A) begin : gChkThru
      chk_sp_write_thru: assert property (
        @(posedge mclk) disable iff (!rstN)
        sCleanWriteA |=> qA == $past(wdataA, 2))
        else $error("single-port write not seen on q after write");
    end else begin : gChkThruReg
      chk_sp_thru_reg: assert property (
        @(posedge mclk) disable iff (!rstN)
        sCleanWriteA ##1 !outClr |=> outClr || qA == $past(wdataA, 3))
        else $error("registered single-port write not seen on q");
      chk_out_clear_now: assert property (
        @(posedge mclk) disable iff (!rstN)
        outClr |-> qA == '0)
        else $error("output clear did not zero q at once");
      chk_out_reg_pipe: assert property (
        @(posedge mclk) disable iff (!rstN)
        !outClr && !$past(outClr) |-> qA == $past(memRdA))
        else $error("output register is not one stage behind array");
    end
    if (HAS_IN_CLR) begin : gChkInClr
      chk_in_clear_late: assert property (
        @(posedge mclk) disable iff (!rstN)
        inClr |-> ##2 $stable(memRdA))
        else $error("cleared input registers still reached the array");
    end else begin : gChkNoInClr
      chk_large_no_inclr: assert property (
        @(posedge mclk) disable iff (!rstN)
        !IS_SP && reB && inClr |=> ctlB_r.rd)
        else $error("large block input clear dropped a read");
    end
  endgenerate

  chk_power_up_q: assert property (
    @(posedge mclk)
    $rose(rstN) |-> qKnownA == KNOWN_AT_RESET && (IS_LARGE || qB == '0))
    else $error("power-up output state is wrong");

  chk_sdp_roles: assert property (
    @(posedge mclk) disable iff (!rstN)
    IS_SDP |-> !ctlA_r.rd && !ctlB_r.wr)
    else $error("simple dual-port port took a forbidden role");

  chk_dsp_halves: assert property (
    @(posedge mclk) disable iff (!rstN)
    IS_DSP |-> !memAddrA[AW_A-1] && memAddrB[AW_B-1])
    else $error("split mode port strayed into the other half");

endmodule

// ==== design/ecram_top_fix.sv ====
`timescale 1ns/1ps
// Intentionally empty.

// ==== test/ecram_user_model.sv ====
// Fabric-side user logic that drives both ports of the embedded RAM.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ps

module ecram_user_model (
  // Clears
  output logic inClr,
  output logic outClr,
  // Port A
  output logic [6:0] addrA,
  output logic [35:0] wdataA,
  output logic weA,
  output logic reA,
  // Port B
  output logic [7:0] addrB,
  output logic [17:0] wdataB,
  output logic weB,
  output logic reB
);
  // ----------------------------------------------------------------------
  // Request tasks
  // ----------------------------------------------------------------------
  task automatic portA(input logic we, input logic re, input logic [6:0] a,
                       input logic [35:0] d);
    weA = we;
    reA = re;
    addrA = a;
    wdataA = d;
  endtask

  task automatic portB(input logic we, input logic re, input logic [7:0] a,
                       input logic [17:0] d);
    weB = we;
    reB = re;
    addrB = a;
    wdataB = d;
  endtask

  // An idle port no longer shows its last address or data.
  task automatic idle();
    portA(1'h0, 1'h0, ~addrA, ~wdataA);
    portB(1'h0, 1'h0, ~addrB, ~wdataB);
  endtask

  task automatic clears(input logic i, input logic o);
    inClr = i;
    outClr = o;
  endtask

  initial begin
    clears(1'h0, 1'h0);
    portA(1'h0, 1'h0, 7'h00, 36'h0);
    portB(1'h0, 1'h0, 8'h00, 18'h0);
  end
endmodule

// ==== test/configurable_embedded_ram_bench.sv ====
// Self-checking bench for a medium true dual-port block, 36/18 wide.
// Assumes port A bypasses its output register and port B uses one.
`timescale 1ns/1ps

module configurable_embedded_ram_bench;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic inClr, outClr, weA, reA, weB, reB, qKnownA, qKnownB;
  logic [6:0] addrA;
  logic [7:0] addrB;
  logic [35:0] wdataA, qA;
  logic [17:0] wdataB, qB;
  logic [35:0] qAL;
  logic [17:0] qBL;
  logic qKnownAL, qKnownBL;
  logic largeWr = 1'h0;
  int n_errors = 0;
  int checks = 0;

  always #5 mclk = ~mclk;

  ecram_user_model user_u (
    .inClr(inClr), .outClr(outClr),
    .addrA(addrA), .wdataA(wdataA), .weA(weA), .reA(reA),
    .addrB(addrB), .wdataB(wdataB), .weB(weB), .reB(reB)
  );

  ecram_top #(
    .KIND(ecram_pkg::KIND_MEDIUM), .MODE(ecram_pkg::MODE_TDP),
    .WIDTH_A(36), .WIDTH_B(18), .OUT_REG_A(1'h0), .OUT_REG_B(1'h1),
    .RDW_OLD(1'h1)
  ) dut_u (
    .mclk(mclk), .nrst(nrst), .inClr(inClr), .outClr(outClr),
    .addrA(addrA), .wdataA(wdataA), .weA(weA), .reA(reA),
    .qA(qA), .qKnownA(qKnownA),
    .addrB(addrB), .wdataB(wdataB), .weB(weB), .reB(reB),
    .qB(qB), .qKnownB(qKnownB)
  );

  // Large block on the same user logic; it sees writes only while loading.
  ecram_top #(
    .KIND(ecram_pkg::KIND_LARGE), .MODE(ecram_pkg::MODE_TDP),
    .WIDTH_A(36), .WIDTH_B(18), .OUT_REG_A(1'h0), .OUT_REG_B(1'h1),
    .RDW_OLD(1'h1)
  ) dut_large_u (
    .mclk(mclk), .nrst(nrst), .inClr(inClr), .outClr(outClr),
    .addrA({7'h00, addrA}), .wdataA(wdataA), .weA(weA && largeWr),
    .reA(reA), .qA(qAL), .qKnownA(qKnownAL),
    .addrB({7'h00, addrB}), .wdataB(wdataB), .weB(weB && largeWr),
    .reB(reB), .qB(qBL), .qKnownB(qKnownBL)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    cyc(2);
    chk("qA", 36'h0, qA);
    chk("qB", 36'h0, {18'h0, qB});
    chk("qKnown", 36'h3, {34'h0, qKnownA, qKnownB});
    chk("large qKnown", 36'h0, {34'h0, qKnownAL, qKnownBL});
    $display("test reset done");
  endtask

  // A wide write read back at once through both ports and both widths.
  task automatic t_wide();
    user_u.portA(1'h1, 1'h0, 7'h05, {18'h3c0f0, 18'h00ff1});
    cyc(1);
    user_u.portA(1'h0, 1'h1, 7'h05, 36'h0);
    user_u.portB(1'h0, 1'h1, 8'h0a, 18'h0);
    cyc(1);
    user_u.portB(1'h0, 1'h1, 8'h0b, 18'h0);
    cyc(1);
    user_u.idle();
    chk("qA", {18'h3c0f0, 18'h00ff1}, qA);
    chk("qB", 36'h0, {18'h0, qB});
    cyc(1);
    chk("qB", 36'h00ff1, {18'h0, qB});
    cyc(1);
    chk("qB", 36'h3c0f0, {18'h0, qB});
    $display("test wide done");
  endtask

  // Two writes in one cycle, then two reads across widths.
  task automatic t_twowrites();
    user_u.portA(1'h1, 1'h0, 7'h02, 36'h0);
    user_u.portB(1'h1, 1'h0, 8'h0e, 18'h2a5a5);
    cyc(1);
    user_u.portA(1'h0, 1'h1, 7'h07, 36'h0);
    user_u.portB(1'h0, 1'h1, 8'h04, 18'h0);
    cyc(1);
    user_u.idle();
    cyc(1);
    chk("qA low lane", 36'h2a5a5, {18'h0, qA[17:0]});
    cyc(1);
    chk("qB", 36'h0, {18'h0, qB});
    $display("test twowrites done");
  endtask

  // B reads the word that A writes in the same cycle: old data.
  task automatic t_collide();
    user_u.portA(1'h1, 1'h0, 7'h05, {18'h11111, 18'h22222});
    user_u.portB(1'h0, 1'h1, 8'h0a, 18'h0);
    cyc(1);
    user_u.portA(1'h0, 1'h0, 7'h7a, 36'h0);
    user_u.portB(1'h0, 1'h1, 8'h0b, 18'h0);
    cyc(1);
    user_u.idle();
    cyc(1);
    chk("qB", 36'h00ff1, {18'h0, qB});
    cyc(1);
    chk("qB", 36'h11111, {18'h0, qB});
    $display("test collide done");
  endtask

  // Output clear acts at once; input clear cancels a captured read.
  task automatic t_clears();
    user_u.portA(1'h0, 1'h1, 7'h05, 36'h0);
    cyc(3);
    user_u.clears(1'h0, 1'h1);
    user_u.portA(1'h0, 1'h1, 7'h02, 36'h0);
    #1;
    chk("qB", 36'h0, {18'h0, qB});
    chk("qA", {18'h11111, 18'h22222}, qA);
    cyc(1);
    user_u.clears(1'h1, 1'h0);
    user_u.idle();
    cyc(1);
    user_u.clears(1'h0, 1'h0);
    cyc(1);
    chk("qA", {18'h11111, 18'h22222}, qA);
    $display("test clears done");
  endtask

  // Large block: a load collides with a read, then writes stay off.
  task automatic t_large();
    largeWr = 1'h1;
    user_u.portA(1'h0, 1'h1, 7'h05, 36'h0);
    user_u.portB(1'h1, 1'h0, 8'h0a, 18'h1e2d3);
    cyc(1);
    largeWr = 1'h0;
    user_u.portB(1'h1, 1'h0, 8'h0a, 18'h01d2c);
    cyc(1);
    chk("large qA", 36'hfffffffff, qAL);
    user_u.clears(1'h1, 1'h0);
    user_u.portB(1'h0, 1'h1, 8'h0a, 18'h0);
    cyc(1);
    user_u.clears(1'h0, 1'h0);
    user_u.idle();
    cyc(1);
    chk("large qA low lane", 36'h1e2d3, {18'h0, qAL[17:0]});
    cyc(1);
    chk("large qB", 36'h1e2d3, {18'h0, qBL});
    $display("test large done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    t_reset();
    cyc(2);
    nrst = 1'h1;
    cyc(3);
    t_wide();
    t_twowrites();
    t_collide();
    t_clears();
    t_large();
    give_verdict();
  end

  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule
